// ==== logic/srbm_params.svh ====
// Functional notes
// RULE_01 - Write stores only lanes with mask set; other lanes keep old bytes.
// RULE_02 - Memory is written only while the write request is high.
// RULE_03 - Unused byte-lane mask reads as all ones; write request alone then rules.
// RULE_04 - Byte-lane mask capture registers have no clear of any kind.
// RULE_05 - Masking works for widths 1, 2, 4, 8, 9, 16, 18, 32 and 36.
// RULE_06 - Widths up to nine bits: mask bit zero qualifies the whole word.
// RULE_07 - Mask bit n picks lane n: eight bits, or nine with parity.
// RULE_08 - Any mix of set and clear mask bits is accepted on a write.
// RULE_09 - Packed: mask bits 1:0 serve first port, bits 3:2 second port.
// RULE_10 - Write cycle read-out: masked-off lane undefined, enabled lane shows new data.
// RULE_11 - Packed mode needs half-size memories, at most 18 bits, one clock.
// RULE_12 - Address register can keep its old value under an address-hold input.
// RULE_13 - Each packed port has its own address hold for its own register.
// RULE_14 - Hold is active high; register output feeds back while it is high.
// RULE_15 - Unused hold reads as low; address loads on every enabled edge.
// RULE_16 - All inputs are registered; read data may use or bypass output register.
// RULE_17 - User logic never asks read and write together on one single port.
// RULE_18 - Written data flows through to the read output in single-port mode.
// RULE_19 - Single port shapes: 4Kx1 up to 128x36, parity shapes included.
// RULE_20 - Clock enable low freezes the whole block, memory array included.
// RULE_21 - Only output registers clear asynchronously, immediately; outputs start cleared.
// RULE_22 - With write request low no location changes, whatever the mask.
// RULE_23 - Output register adds one cycle of read latency over bypass.
`ifndef SRBM_PARAMS_SVH
`define SRBM_PARAMS_SVH
`define SRBM_ADDR_W     12
`define SRBM_DATA_W     36
`define SRBM_MASK_W     4
`define SRBM_PORT_MASK  2
`define SRBM_BITS_PAR   4608
`define SRBM_BITS_PLAIN 4096
`define SRBM_LANE_PLAIN 8
`define SRBM_LANE_PAR   9
`define SRBM_BYTE_W     9
`define SRBM_PACK_MAX_W 18
`define SRBM_MASK_ONES  4'hf
`define SRBM_Q_RST      36'h0
`endif

// ==== logic/srbm_pkg.sv ====
`default_nettype none
`include "srbm_params.svh"
package srbm_pkg;
  // One port request as captured from user logic
  typedef struct packed {
    logic                    we;
    logic                    hold;
    logic [`SRBM_ADDR_W-1:0] addr;
    logic [`SRBM_DATA_W-1:0] data;
  } srbm_req_t;
  typedef logic [`SRBM_DATA_W-1:0] srbm_word_t;
  typedef logic [`SRBM_MASK_W-1:0] srbm_mask_t;
endpackage
`default_nettype wire

// ==== logic/srbm_in_reg.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srbm_params.svh"
module srbm_in_reg #(
  parameter int MASK_USED = 1,
  parameter int HOLD_USED = 1
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_clk_en,
  input  wire srbm_pkg::srbm_req_t  i_req,
  input  wire srbm_pkg::srbm_mask_t i_mask,
  output var  srbm_pkg::srbm_req_t  o_req,
  output var  srbm_pkg::srbm_mask_t o_mask
);
  import srbm_pkg::*;

  srbm_req_t  req_ff;
  srbm_req_t  nxt_req;
  srbm_mask_t mask_ff;
  srbm_mask_t nxt_mask;
  logic       hold_eff;

  // Unconnected hold is treated as low
  assign hold_eff = (HOLD_USED != 0) && i_req.hold; // [RULE_15]

  // Input capture; nothing reaches the array unregistered
  always_comb begin
    nxt_req  = req_ff;
    nxt_mask = mask_ff;
    if (i_clk_en) begin // [RULE_20]
      nxt_req = i_req; // [RULE_16]
      if (hold_eff) begin
        nxt_req.addr = req_ff.addr; // [RULE_12] [RULE_14]
      end
      // Unused mask lanes write as if enabled
      nxt_mask = (MASK_USED != 0) ? i_mask : `SRBM_MASK_ONES; // [RULE_03]
    end
    // Only the write qualifier needs a known state after reset
    if (i_rst) begin
      nxt_req.we = 1'b0;
    end
  end

  // Mask register deliberately has no clear path
  always_ff @(posedge i_core_clk) begin
    req_ff  <= nxt_req;
    mask_ff <= nxt_mask; // [RULE_04]
  end

  assign o_req  = req_ff;
  assign o_mask = mask_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_hold_keeps: assert property (i_clk_en && hold_eff |=> $stable(req_ff.addr)) // [RULE_14]
    else $error("address moved while hold was high");
  a_addr_loads: assert property (i_clk_en && !hold_eff |=> req_ff.addr == $past(i_req.addr)) // [RULE_15]
    else $error("address not loaded with hold low");
  c_hold_seen: cover property (i_clk_en && hold_eff ##1 i_clk_en && hold_eff);
endmodule
`default_nettype wire

// ==== logic/srbm_ram_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srbm_params.svh"
module srbm_ram_top #(
  parameter int DATA_W    = 36,
  parameter int OUT_REG   = 0,
  parameter int PACKED    = 0,
  parameter int MASK_USED = 1,
  parameter int HOLD_USED = 1
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_out_aclr,
  input  wire logic                 i_clk_en,
  input  wire srbm_pkg::srbm_req_t  i_req_a,
  input  wire srbm_pkg::srbm_req_t  i_req_b,
  input  wire srbm_pkg::srbm_mask_t i_byte_mask,
  output var  srbm_pkg::srbm_word_t o_q_a,
  output var  srbm_pkg::srbm_word_t o_q_b
);
  import srbm_pkg::*;

  // Shape of the array; parity widths use the full bit count
  localparam int PARITY = (DATA_W == 9 || DATA_W == 18 || DATA_W == 36) ? 1 : 0;
  localparam int BITS   = (PARITY != 0) ? `SRBM_BITS_PAR : `SRBM_BITS_PLAIN; // [RULE_19]
  localparam int DEPTH  = BITS / DATA_W; // [RULE_19]
  localparam int AW     = $clog2(DEPTH);
  // Narrow words form a single lane covering the whole word
  localparam int LW     = (DATA_W <= `SRBM_BYTE_W) ? DATA_W :
                          ((PARITY != 0) ? `SRBM_LANE_PAR : `SRBM_LANE_PLAIN); // [RULE_06] [RULE_07]
  localparam int LANES  = DATA_W / LW;
  localparam int NP     = (PACKED != 0) ? 2 : 1;

  srbm_req_t        req_in [2];
  srbm_mask_t       mask_in [2];
  srbm_req_t        req_q [2];
  srbm_mask_t       mask_q [2];
  logic [AW-1:0]    ea [2];
  logic [DATA_W-1:0] mem [DEPTH];
  srbm_word_t       rd_ff [2];
  srbm_word_t       nxt_rd [2];
  srbm_word_t       out_ff [2];
  srbm_word_t       nxt_out [2];

  // Mask split: packed ports own two bits each
  always_comb begin
    req_in[0] = i_req_a;
    req_in[1] = i_req_b;
    if (PACKED != 0) begin
      mask_in[0] = {2'h0, i_byte_mask[1:0]}; // [RULE_09]
      mask_in[1] = {2'h0, i_byte_mask[3:2]}; // [RULE_09]
    end else begin
      mask_in[0] = i_byte_mask; // [RULE_07]
      mask_in[1] = `SRBM_MASK_ONES;
    end
  end

  // One input stage per live port, each with its own hold
  for (genvar p = 0; p < 2; p++) begin : g_port
    if (p < NP) begin : g_live
      srbm_in_reg #(
        .MASK_USED (MASK_USED),
        .HOLD_USED (HOLD_USED)
      ) u_in (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clk_en   (i_clk_en),
        .i_req      (req_in[p]),
        .i_mask     (mask_in[p]),
        .o_req      (req_q[p]),
        .o_mask     (mask_q[p])
      ); // [RULE_13]
    end else begin : g_idle
      assign req_q[p]  = '0;
      assign mask_q[p] = '0;
    end
    // Packed ports each get one half of the array
    if (PACKED != 0) begin : g_half
      assign ea[p] = {1'(p), req_q[p].addr[AW-2:0]}; // [RULE_11]
    end else begin : g_full
      assign ea[p] = req_q[p].addr[AW-1:0];
    end
  end

  // Array write; halves never overlap so both ports may write at once.
  // No reset: contents are user data, not control state.
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en) begin // [RULE_20]
      for (int p = 0; p < NP; p++) begin
        for (int l = 0; l < LANES; l++) begin
          // Write only with request high and the lane's mask set
          if (req_q[p].we && mask_q[p][l]) begin // [RULE_02] [RULE_22] [RULE_08]
            mem[ea[p]][l*LW +: LW] <= req_q[p].data[l*LW +: LW]; // [RULE_01] [RULE_05]
          end
        end
      end
    end
  end

  // Read path; write has priority, user keeps read and write apart
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_rd[p] = rd_ff[p];
      if (i_clk_en) begin // [RULE_20]
        nxt_rd[p] = `SRBM_Q_RST;
        nxt_rd[p][DATA_W-1:0] = mem[ea[p]]; // [RULE_16]
        if (req_q[p].we) begin // [RULE_17]
          for (int l = 0; l < LANES; l++) begin
            // Masked-off lanes show stored bytes, a legal pick for don't care
            if (mask_q[p][l]) begin
              nxt_rd[p][l*LW +: LW] = req_q[p].data[l*LW +: LW]; // [RULE_10] [RULE_18]
            end
          end
        end
      end
      if (p >= NP || i_rst) begin
        nxt_rd[p] = `SRBM_Q_RST;
      end
    end
  end

  // Flow-through stage, cleared by the synchronous reset only
  always_ff @(posedge i_core_clk) begin
    rd_ff <= nxt_rd;
  end

  // Pipelined output stage
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_out[p] = out_ff[p];
      if (i_clk_en) begin // [RULE_20]
        nxt_out[p] = rd_ff[p]; // [RULE_23]
      end
      if (i_rst) begin
        nxt_out[p] = `SRBM_Q_RST;
      end
    end
  end

  // Only this stage sees the asynchronous clear, so it acts at once
  always_ff @(posedge i_core_clk or posedge i_out_aclr) begin
    if (i_out_aclr) begin
      out_ff[0] <= `SRBM_Q_RST; // [RULE_21]
      out_ff[1] <= `SRBM_Q_RST;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // Output source fixed at build time; either way a flop drives the pin
  if (OUT_REG != 0) begin : g_piped
    assign o_q_a = out_ff[0]; // [RULE_16]
    assign o_q_b = out_ff[1];
  end else begin : g_flow
    assign o_q_a = rd_ff[0]; // [RULE_16]
    assign o_q_b = rd_ff[1];
  end

  // Helpers for the checks below
  logic [DATA_W-1:0] word0;
  logic [LW-1:0]     lane0;
  logic [LW-1:0]     wdat0;
  assign word0 = mem[ea[0]];
  assign lane0 = mem[ea[0]][LW-1:0];
  assign wdat0 = req_q[0].data[LW-1:0];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_width_legal: assert property (DATA_W inside {1, 2, 4, 8, 9, 16, 18, 32, 36}) // [RULE_05]
    else $error("unsupported data width");
  a_packed_legal: assert property (PACKED == 0 || DATA_W <= `SRBM_PACK_MAX_W) // [RULE_11]
    else $error("packed port wider than allowed");
  // Next request may move the address; the written word is then out of view
  a_lane_written: assert property ( // [RULE_01]
    i_clk_en && req_q[0].we && mask_q[0][0]
    |=> ($past(ea[0]) != ea[0]) || lane0 === $past(wdat0))
    else $error("enabled lane not written");
  a_lane_kept: assert property ( // [RULE_01]
    i_clk_en && req_q[0].we && !mask_q[0][0]
    |=> ($past(ea[0]) != ea[0]) || lane0 === $past(lane0))
    else $error("masked lane was overwritten");
  // Case equality: words never written stay unknown and must still compare
  a_idle_no_write: assert property ( // [RULE_22]
    (!req_q[0].we || !i_clk_en) && (NP == 1 || !req_q[1].we) ##1 $stable(ea[0])
    |-> word0 === $past(word0))
    else $error("array changed without a write");
  // The clear may strike while frozen; only clear-free cycles are judged
  a_freeze_read: assert property ( // [RULE_20]
    !i_clk_en && !i_out_aclr ##1 !i_out_aclr
    |-> $stable(rd_ff[0]) && $stable(out_ff[0]))
    else $error("state moved with clock enable low");
  a_flow_new: assert property ( // [RULE_18]
    i_clk_en && req_q[0].we && mask_q[0][0] |=> rd_ff[0][LW-1:0] == $past(wdat0))
    else $error("written lane not on read output");
  a_read_word: assert property ( // [RULE_16]
    i_clk_en && !req_q[0].we |=> rd_ff[0][DATA_W-1:0] === $past(word0))
    else $error("read data does not match array");
  a_out_later: assert property ( // [RULE_23]
    i_clk_en && !i_out_aclr ##1 !i_out_aclr |-> out_ff[0] === $past(rd_ff[0]))
    else $error("output stage not one cycle behind");
  a_aclr_clear: assert property (i_out_aclr |-> out_ff[0] == `SRBM_Q_RST) // [RULE_21]
    else $error("output stage not cleared");

  c_part_write: cover property (i_clk_en && req_q[0].we && mask_q[0] != `SRBM_MASK_ONES);
  c_read_after: cover property (i_clk_en && req_q[0].we ##1 i_clk_en && !req_q[0].we);
  c_frozen: cover property (!i_clk_en ##1 !i_clk_en);
endmodule
`default_nettype wire

// ==== bench/srbm_user_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Fabric-side user logic; one request a cycle
module srbm_user_model (
  input  wire logic                 i_core_clk,
  output var  logic                 o_clk_en,
  output var  logic                 o_aclr,
  output var  srbm_pkg::srbm_req_t  o_req,
  output var  srbm_pkg::srbm_mask_t o_mask
);
  import srbm_pkg::*;
  // Idle read of word zero until told otherwise
  initial begin
    o_clk_en = 1'b1;
    o_aclr   = 1'b0;
    o_req    = '0;
    o_mask   = 4'hf;
  end
  // Moves only after a falling edge; one we bit, so never read and write at once
  task automatic drive(input logic en, we, hold, input logic [11:0] a, input srbm_word_t d,
                       input logic [3:0] m);
    @(negedge i_core_clk);
    o_clk_en = en;
    o_req    = '{we: we, hold: hold, addr: a, data: d};
    o_mask   = m;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import srbm_pkg::*;
  logic        i_core_clk;
  logic        i_rst;
  logic        clk_en;
  logic        aclr;
  srbm_req_t   req;
  srbm_req_t   req_b;
  srbm_word_t  q_ka;
  srbm_word_t  q_kb;
  srbm_word_t  q_u;
  srbm_mask_t  mask;
  srbm_word_t  q_flow;
  srbm_word_t  q_pipe;
  srbm_word_t  ref_mem [0:127];
  srbm_word_t  prev_exp;
  srbm_word_t  prev_care;
  logic [11:0] eff;
  int          n_errors;
  int          cmp_count;
  // 10 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  srbm_user_model srbm_user_model_inst (.i_core_clk(i_core_clk), .o_clk_en(clk_en), .o_aclr(aclr),
    .o_req(req), .o_mask(mask));
  // Flow-through and pipelined copies see the same stimulus
  srbm_ram_top #(.OUT_REG(0)) srbm_ram_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_out_aclr(aclr),
    .i_clk_en(clk_en), .i_req_a(req), .i_req_b('0), .i_byte_mask(mask), .o_q_a(q_flow), .o_q_b());
  srbm_ram_top #(.OUT_REG(1)) srbm_ram_top_p_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_out_aclr(aclr),
    .i_clk_en(clk_en), .i_req_a(req), .i_req_b('0), .i_byte_mask(mask), .o_q_a(q_pipe), .o_q_b());
  // Packed pair of 18-bit halves; port B driven by the bench directly
  srbm_ram_top #(.DATA_W(18), .PACKED(1)) srbm_ram_top_k_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_out_aclr(aclr), .i_clk_en(clk_en), .i_req_a(req), .i_req_b(req_b), .i_byte_mask(mask),
    .o_q_a(q_ka), .o_q_b(q_kb));
  // Mask and hold marked unused: full-word writes, address always loads
  srbm_ram_top #(.MASK_USED(0), .HOLD_USED(0)) srbm_ram_top_u_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_out_aclr(aclr), .i_clk_en(clk_en), .i_req_a(req), .i_req_b('0), .i_byte_mask(mask),
    .o_q_a(q_u), .o_q_b());
  // Only lanes in care are compared; masked-off write lanes are undefined
  task automatic check(input srbm_word_t seen, exp, care);
    cmp_count++;
    if ((seen & care) !== (exp & care)) begin
      n_errors++;
      $display("Error at %0t: read %h, want %h", $time, seen, exp);
    end
  endtask
  // Nine-bit lanes of a 36-bit word
  function automatic srbm_word_t lanes(input logic [3:0] m);
    srbm_word_t w;
    w = '0;
    for (int n = 0; n < 4; n++) w[9*n +: 9] = {9{m[n]}};
    return w;
  endfunction
  // Request held four edges; flow result after edge two, piped after edge three
  task automatic xfer(input logic we, hold, input logic [11:0] a, input srbm_word_t d, input logic [3:0] m);
    srbm_word_t exp;
    srbm_word_t care;
    srbm_word_t qf1;
    srbm_word_t qp1;
    if (!hold) eff = a;
    care = we ? lanes(m) : '1;
    if (we) ref_mem[eff[6:0]] = (ref_mem[eff[6:0]] & ~care) | (d & care);
    exp = ref_mem[eff[6:0]];
    srbm_user_model_inst.drive(1'b1, we, hold, a, d, m);
    repeat (2) @(negedge i_core_clk);
    qf1 = q_flow;
    qp1 = q_pipe;
    @(negedge i_core_clk);
    check(qf1, exp, care);
    check(q_pipe, exp, care);
    check(qp1, prev_exp, prev_care);
    prev_exp = exp;
    prev_care = care;
  endtask
  // Every mask pattern, read back after each
  task automatic t_masks;
    xfer(1'b1, 1'b0, 12'h001, 36'h0, 4'hf);
    for (int m = 0; m < 16; m++) begin
      xfer(1'b1, 1'b0, 12'h001, 36'hfedcba987 - 36'(m * 'h1111), 4'(m));
      xfer(1'b0, 1'b0, 12'h001, 36'h0, 4'hf);
    end
    xfer(1'b0, 1'b0, 12'h001, 36'h5a5a5a5a5, 4'hf);
    check(q_u, 36'hfedcba987 - 36'(15 * 'h1111), '1);
  endtask
  // Held address serves both reads and writes
  task automatic t_hold;
    xfer(1'b1, 1'b0, 12'h002, 36'h111111111, 4'hf);
    xfer(1'b1, 1'b0, 12'h003, 36'h222222222, 4'hf);
    xfer(1'b0, 1'b0, 12'h002, 36'h0, 4'hf);
    xfer(1'b0, 1'b1, 12'h003, 36'h0, 4'hf);
    xfer(1'b1, 1'b1, 12'h003, 36'h333333333, 4'hf);
    xfer(1'b0, 1'b0, 12'h003, 36'h0, 4'hf);
    xfer(1'b0, 1'b0, 12'h002, 36'h0, 4'hf);
    check(q_u, 36'h111111111, '1);
  endtask
  // Disabled clock: a pending write must not land
  task automatic t_clken;
    srbm_word_t held;
    held = q_flow;
    srbm_user_model_inst.drive(1'b0, 1'b1, 1'b0, 12'h002, 36'h0, 4'hf);
    repeat (3) @(negedge i_core_clk);
    check(q_flow, held, '1);
    check(q_pipe, held, '1);
    prev_care = '0;
    xfer(1'b0, 1'b0, 12'h002, 36'h0, 4'hf);
  endtask
  // Two half-size memories in one block; each owns two mask bits and its own hold
  task automatic t_packed;
    srbm_word_t wa;
    srbm_word_t wb;
    wa = 36'h21234;
    wb = 36'h15678;
    srbm_user_model_inst.drive(1'b1, 1'b1, 1'b0, 12'h005, wa, 4'hf);
    req_b = '{we: 1'b1, hold: 1'b0, addr: 12'h005, data: wb};
    @(negedge i_core_clk);
    srbm_user_model_inst.drive(1'b1, 1'b1, 1'b0, 12'h005, 36'h3ffff, 4'h9);
    req_b = '{we: 1'b1, hold: 1'b0, addr: 12'h005, data: 36'h3ffff};
    @(negedge i_core_clk);
    // Port B asks for another word but holds its address
    srbm_user_model_inst.drive(1'b1, 1'b0, 1'b0, 12'h005, 36'h0, 4'hf);
    req_b = '{we: 1'b0, hold: 1'b1, addr: 12'h009, data: 36'h0};
    repeat (2) @(negedge i_core_clk);
    check(q_ka, (wa & ~lanes(4'h1)) | (36'h3ffff & lanes(4'h1)), '1);
    check(q_kb, (wb & ~lanes(4'h2)) | (36'h3ffff & lanes(4'h2)), '1);
    req_b = '0;
  endtask
  // Clear hits the output register at once, the flow path not at all
  task automatic t_aclr;
    srbm_word_t held;
    held = q_flow;
    @(negedge i_core_clk);
    srbm_user_model_inst.o_aclr = 1'b1;
    #1;
    check(q_pipe, '0, '1);
    check(q_flow, held, '1);
    @(negedge i_core_clk);
    srbm_user_model_inst.o_aclr = 1'b0;
    prev_care = '0;
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    prev_exp = '0;
    prev_care = '0;
    eff = '0;
    req_b = '0;
    i_rst = 1'b1;
    repeat (6) @(negedge i_core_clk);
    i_rst = 1'b0;
    check(q_flow, '0, '1);
    check(q_pipe, '0, '1);
    t_masks();
    t_hold();
    t_clken();
    t_packed();
    t_aclr();
    complete_run();
  end
  // Guard against a stuck run
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
